// ---- rtl/dkc_pkg.sv ----
package dkc_pkg;
  // Register offsets on the plain register port.
  localparam logic [2:0] RA_RANGE = 3'h0;
  localparam logic [2:0] RA_CFG_A = 3'h1;
  localparam logic [2:0] RA_CFG_B = 3'h2;
  localparam logic [2:0] RA_CFG_C = 3'h3;
  localparam logic [2:0] RA_TASK = 3'h4;
  localparam logic [2:0] RA_STAT = 3'h5;
  localparam logic [2:0] RA_ADDR_LO = 3'h6;
  localparam logic [2:0] RA_CTRL = 3'h7;

  // Word fields count bit 0 as the least significant bit of a 16-bit word.
  localparam int TW_CRC_IGN = 7;
  localparam int TW_HA = 3;
  localparam int TW_EXT_GAP = 2;
  localparam int TW_NO_RETRY = 1;
  localparam int ST_BUSY = 15;
  localparam int ST_RD_ERR = 11;
  localparam int ST_PROG_ERR = 10;
  localparam int ST_NOT_FOUND = 8;
  localparam int CTRL_DIR = 0;
  localparam int MADDR_W = 24;

  // Command code fields of the task word.
  localparam logic [1:0] CODE_MEDIA = 2'h2;
  localparam logic [2:0] FN_FMT = 3'h0;
  localparam logic [2:0] FN_DATA = 3'h1;
  localparam logic [2:0] FN_DFMT = 3'h2;
  localparam logic [2:0] FN_DDATA = 3'h3;
  localparam logic [2:0] FN_ID = 3'h4;

  // Reset values, fixed bytes and field lengths.
  localparam logic [15:0] CFG_C_RST = 16'h006d;
  localparam logic [7:0] HA_END_BYTE = 8'hf0;
  localparam logic [7:0] SYNC_BYTE = 8'h01;
  localparam logic [9:0] SECT_LEN = 10'h100;
  localparam logic [9:0] DIAG_LEN = 10'h107;
  localparam logic [9:0] ID_LEN = 10'h004;
  localparam logic [9:0] HA_LEN = 10'h015;
  localparam int SECTORS_DEF = 95;
  localparam int PLO_DEF = 12;
  localparam int EXT_GAP_DEF = 32;
  localparam int RETRY_DEF = 8;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_WIDX = 8'h02, S_SRCH = 8'h04, S_RDAT = 8'h08,
    S_DRAIN = 8'h10, S_FILL = 8'h20, S_WRT = 8'h40, S_RDID = 8'h80
  } dkc_state_type;
  typedef enum logic [2:0] {
    OP_NONE, OP_FMTW, OP_DFMT, OP_RD, OP_WR, OP_DRD, OP_DWR, OP_RDID
  } dkc_op_type;
  typedef enum logic [1:0] {FK_DATA, FK_HA, FK_FMT} dkc_frame_type;
  typedef enum logic [2:0] {
    F_GAP, F_PLO, F_SYNC, F_ID, F_DATA, F_HA
  } dkc_field_type;
endpackage

// ---- rtl/dkc_seq.sv ----
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
// Function
// - Leftover range stays readable after early end.
// - ID read error stops format read unless ignored.
// - ID field error costs only its bytes.
// - Zero range ends task at once.
// - Home address record is 21 bytes, F0 last.
// - Format writes all sectors from index, IDs fetched.
// - Format data fields get the filler byte.
// - Wrong format range sets program error.
// - Bad sectors get complemented ID CRC.
// - Extended gap follows home address when selected.
// - Read finds sector, buffers it, drains to memory.
// - Good sector bumps sector number, continue.
// - Two index marks without match: not found.
// - Data field error stops, sector number kept.
// - ID error during search sets, then clears flag.
// - Retry-inhibit bit suppresses read retries.
// - Write fills buffer, writes sector, refills.
// - Data and diagnostic writes lead with phase_lock and sync.
// - Short write range pads with zeros.
// - Diagnostic write sends correction bytes from memory.
// - Diagnostic read returns correction field uncorrected.
// - Diagnostic format complements CRC, patterned data.
// - Config B holds sector and track address.
// - Filler byte resets to 6D.
// - Range drops by one per memory byte.
module dkc_seq #(
  parameter int SECTORS = dkc_pkg::SECTORS_DEF,
  parameter int PHASE_LOCK = dkc_pkg::PLO_DEF,
  parameter int EXT_GAP = dkc_pkg::EXT_GAP_DEF,
  parameter int RETRY_MAX = dkc_pkg::RETRY_DEF,
  parameter int BUF_LEN = 263
) (
  input wire logic ref_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [2:0] reg_addr, // Register index.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_we, // Write strobe.
  input wire logic reg_re, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, one cycle after strobe.
  output logic mem_req, // Memory byte request.
  output logic mem_we, // Memory request is a write.
  output logic [dkc_pkg::MADDR_W-1:0] mem_addr, // Memory byte address.
  output logic [7:0] mem_wdata, // Byte to memory.
  input wire logic [7:0] mem_rdata, // Byte from memory, with ack.
  input wire logic mem_ack, // Memory request done.
  input wire logic med_index, // Index mark pulse.
  input wire logic med_id_valid, // ID field read pulse.
  input wire logic [31:0] med_id, // ID field contents.
  input wire logic med_id_err, // ID field CRC error.
  input wire logic med_rd_valid, // Data field byte strobe.
  input wire logic [7:0] med_rd_data, // Data field byte.
  input wire logic med_rd_end, // Data field end pulse.
  input wire logic med_rd_err, // Field uncorrectable, with end.
  output logic med_wr_valid, // Write byte valid.
  output logic [7:0] med_wr_data, // Write byte.
  output dkc_pkg::dkc_field_type med_wr_field, // Kind of write byte.
  output logic med_wr_crc_inv, // Complement CRC of this ID.
  input wire logic med_wr_ready, // Media takes the byte.
  output logic med_search, // Search for matching ID.
  output logic med_read, // Read the next data field.
  output logic med_raw_ecc, // Correction bytes pass raw.
  output logic [9:0] med_cyl, // Cylinder address.
  output logic [7:0] med_track, // Track address.
  output logic med_lower, // Lower surface selected.
  output logic busy, // Task in progress.
  output logic eop // End-of-operation pulse.
);
  import dkc_pkg::*;

  localparam logic [15:0] FMT_RANGE = 16'(int'(ID_LEN) * SECTORS);

  typedef struct packed {
    dkc_state_type st;
    dkc_op_type op;
    dkc_frame_type fk;
    logic [15:0] range;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] cfg_c;
    logic [15:0] task_w;
    logic dir;
    logic [MADDR_W-1:0] maddr;
    logic rderr;
    logic prog;
    logic nf;
    logic eop;
    logic [15:0] rdata;
    logic [BUF_LEN-1:0][7:0] bufm;
    logic [9:0] cnt;
    logic [9:0] blen;
    logic [1:0] idx;
    logic [3:0] retry;
    logic [6:0] sect;
    logic mreq;
    logic mwe;
    logic [7:0] mwd;
    logic wv;
    logic [7:0] wd;
    dkc_field_type wf;
    logic winv;
  } dkc_regs_type;

  dkc_regs_type s;
  dkc_regs_type n;
  logic [9:0] i;
  logic [9:0] tot;
  logic [9:0] flen;
  logic ha;
  logic fin;

  // Command decode; the direction bit picks read or write flavour.
  function automatic dkc_op_type op_of(logic [15:0] tw, logic rd);
    op_of = OP_NONE;
    if (tw[15:14] == CODE_MEDIA) begin
      case (tw[10:8])
        FN_FMT, FN_ID: op_of = rd ? OP_RDID : OP_FMTW;
        FN_DFMT: op_of = rd ? OP_RDID : OP_DFMT;
        FN_DATA: op_of = rd ? OP_RD : OP_WR;
        FN_DDATA: op_of = rd ? OP_DRD : OP_DWR;
        default: op_of = OP_NONE;
      endcase
    end
  endfunction

  function automatic logic is_fmt(dkc_op_type o);
    is_fmt = (o == OP_FMTW) || (o == OP_DFMT);
  endfunction

  // Diagnostic data commands carry the correction bytes too.
  function automatic logic [9:0] dat_len(dkc_op_type o);
    dat_len = (o == OP_DRD || o == OP_DWR) ? DIAG_LEN : SECT_LEN;
  endfunction

  function automatic logic rng_bad(dkc_op_type o, logic h, logic [15:0] r);
    rng_bad = 1'b0;
    if (is_fmt(o) && !h) begin
      rng_bad = (r != FMT_RANGE);
    end
    if (o == OP_DRD || o == OP_DWR) begin
      rng_bad = (r != {6'h00, DIAG_LEN});
    end
  endfunction

  // Next-state logic for registers, sequencer and both data paths.
  always_comb begin
    n = s;
    fin = 1'b0;
    ha = s.task_w[TW_HA];
    i = 10'h000;
    n.eop = 1'b0;
    n.rdata = 16'h0000;
    case (s.fk)
      FK_HA: tot = s.task_w[TW_EXT_GAP] ? HA_LEN + 10'(EXT_GAP) : HA_LEN;
      FK_FMT: tot = ID_LEN + SECT_LEN;
      default: tot = 10'(PHASE_LOCK) + 10'h001 + dat_len(s.op);
    endcase
    if (is_fmt(s.op)) begin
      flen = ha ? HA_LEN - 10'h001 : ID_LEN;
    end else begin
      flen = dat_len(s.op);
    end

    // Register reads; the range readback shows any residue.
    if (reg_re) begin
      case (reg_addr)
        RA_RANGE: n.rdata = s.range;
        RA_CFG_A: n.rdata = s.cfg_a;
        RA_CFG_B: n.rdata = s.cfg_b;
        RA_CFG_C: n.rdata = s.cfg_c;
        RA_STAT: begin
          n.rdata[ST_BUSY] = (s.st != S_IDLE);
          n.rdata[ST_RD_ERR] = s.rderr;
          n.rdata[ST_PROG_ERR] = s.prog;
          n.rdata[ST_NOT_FOUND] = s.nf;
        end
        RA_ADDR_LO: n.rdata = s.maddr[15:0];
        RA_CTRL: n.rdata = {s.maddr[23:16], 7'h00, s.dir};
        default: n.rdata = s.task_w;
      endcase
    end

    // Writes are taken only while idle, so hardware owns the
    // range, address and sector fields for the whole task.
    if (reg_we && s.st == S_IDLE) begin
      case (reg_addr)
        RA_RANGE: n.range = reg_wdata;
        RA_CFG_A: n.cfg_a = reg_wdata;
        RA_CFG_B: n.cfg_b = reg_wdata;
        RA_CFG_C: n.cfg_c = reg_wdata;
        RA_ADDR_LO: n.maddr[15:0] = reg_wdata;
        RA_CTRL: begin
          n.maddr[23:16] = reg_wdata[15:8];
          n.dir = reg_wdata[CTRL_DIR];
        end
        RA_TASK: begin
          n.task_w = reg_wdata;
          n.op = op_of(reg_wdata, s.dir);
          n.rderr = 1'b0;
          n.prog = 1'b0;
          n.nf = 1'b0;
          n.idx = 2'h0;
          n.retry = 4'h0;
          n.cnt = 10'h000;
          n.sect = 7'h00;
          if (n.op == OP_NONE || s.range == 16'h0000) begin
            n.eop = 1'b1;
          end else if (rng_bad(n.op, reg_wdata[TW_HA], s.range)) begin
            n.prog = 1'b1;
            n.eop = 1'b1;
          end else if (n.op == OP_RD || n.op == OP_DRD) begin
            n.st = S_SRCH;
          end else if (n.op == OP_WR || n.op == OP_DWR) begin
            n.st = S_FILL;
          end else if (is_fmt(n.op) && reg_wdata[TW_HA]) begin
            n.st = S_FILL;
          end else begin
            n.st = S_WIDX;
          end
        end
        default: ;
      endcase
    end

    case (s.st)
      // Format commands start at the index mark, except a home address write.
      S_WIDX: begin
        if (med_index) begin
          n.cnt = 10'h000;
          if (is_fmt(s.op)) begin
            n.st = S_FILL;
          end else begin
            n.st = ha ? S_RDAT : S_RDID;
          end
        end
      end
      // Search: ID errors count as misses but are remembered.
      S_SRCH: begin
        if (med_id_valid) begin
          if (med_id_err) begin
            n.rderr = 1'b1;
          end else if (med_id == {s.cfg_a, s.cfg_b}) begin
            n.rderr = 1'b0;
            n.cnt = 10'h000;
            n.fk = FK_DATA;
            n.st = (s.op == OP_WR || s.op == OP_DWR) ? S_WRT : S_RDAT;
          end
        end
        if (med_index && n.st == S_SRCH) begin
          if (s.idx == 2'h1) begin
            n.nf = 1'b1;
            fin = 1'b1;
          end else begin
            n.idx = s.idx + 2'h1;
          end
        end
      end
      // Data field (or home address record) into the buffer.
      S_RDAT: begin
        if (med_rd_valid && s.cnt < 10'(BUF_LEN)) begin
          n.bufm[s.cnt[8:0]] = med_rd_data;
          n.cnt = s.cnt + 10'h001;
        end
        if (med_rd_end) begin
          if (med_rd_err && (s.op == OP_RD || !s.task_w[TW_CRC_IGN])
              && s.op != OP_DRD) begin
            if (!s.task_w[TW_NO_RETRY] && s.retry < 4'(RETRY_MAX)) begin
              n.retry = s.retry + 4'h1;
              n.idx = 2'h0;
              n.cnt = 10'h000;
              n.st = (s.op == OP_RD) ? S_SRCH : S_WIDX;
            end else begin
              n.rderr = 1'b1;
              fin = 1'b1;
            end
          end else begin
            n.blen = n.cnt;
            n.cnt = 10'h000;
            n.st = S_DRAIN;
            if (s.op != OP_RDID) begin
              n.cfg_b[7:0] = s.cfg_b[7:0] + 8'h01;
            end
          end
        end
      end
      // One ID after another to memory until range or index ends it.
      S_RDID: begin
        if (med_id_valid) begin
          if (med_id_err && !s.task_w[TW_CRC_IGN]) begin
            n.range = (s.range > 16'h0004) ? s.range - 16'h0004
                                           : 16'h0000;
            n.rderr = 1'b1;
            fin = 1'b1;
          end else begin
            for (int k = 0; k < 4; k++) begin
              n.bufm[k] = med_id[31 - 8 * k -: 8];
            end
            n.blen = ID_LEN;
            n.cnt = 10'h000;
            n.st = S_DRAIN;
          end
        end else if (med_index) begin
          fin = 1'b1;
        end
      end
      // Buffer to memory; ends early once the range is used up.
      S_DRAIN: begin
        if (s.cnt == s.blen || s.range == 16'h0000) begin
          n.cnt = 10'h000;
          n.idx = 2'h0;
          if (s.range == 16'h0000 || s.op == OP_DRD
              || (s.op == OP_RDID && ha)) begin
            fin = 1'b1;
          end else begin
            n.st = (s.op == OP_RDID) ? S_RDID : S_SRCH;
          end
        end else if (mem_ack) begin
          n.mreq = 1'b0;
          n.cnt = s.cnt + 10'h001;
          n.maddr = s.maddr + 24'h000001;
          n.range = s.range - 16'h0001;
        end else begin
          n.mreq = 1'b1;
          n.mwe = 1'b1;
          n.mwd = s.bufm[s.cnt[8:0]];
        end
      end
      // Memory to buffer: a sector, an ID, or the home address.
      S_FILL: begin
        if (s.cnt == flen || s.range == 16'h0000) begin
          n.blen = s.cnt;
          n.cnt = 10'h000;
          n.idx = 2'h0;
          if (is_fmt(s.op)) begin
            n.fk = ha ? FK_HA : FK_FMT;
            n.st = S_WRT;
          end else begin
            n.st = S_SRCH;
          end
        end else if (mem_ack) begin
          n.mreq = 1'b0;
          n.bufm[s.cnt[8:0]] = mem_rdata;
          n.cnt = s.cnt + 10'h001;
          n.maddr = s.maddr + 24'h000001;
          n.range = s.range - 16'h0001;
        end else begin
          n.mreq = 1'b1;
          n.mwe = 1'b0;
        end
      end
      // Byte stream to the media, one byte per accepted beat.
      S_WRT: begin
        if (!s.wv || med_wr_ready) begin
          n.wv = 1'b0;
          n.winv = 1'b0;
          if (s.cnt == tot) begin
            n.cnt = 10'h000;
            case (s.fk)
              FK_DATA: begin
                n.cfg_b[7:0] = s.cfg_b[7:0] + 8'h01;
                if (s.range == 16'h0000) begin
                  fin = 1'b1;
                end else begin
                  n.st = S_FILL;
                end
              end
              FK_FMT: begin
                n.sect = s.sect + 7'h01;
                if (s.sect == 7'(SECTORS - 1)) begin
                  fin = 1'b1;
                end else begin
                  n.st = S_FILL;
                end
              end
              default: fin = 1'b1;
            endcase
          end else begin
            n.wv = 1'b1;
            n.cnt = s.cnt + 10'h001;
            case (s.fk)
              FK_HA: begin
                n.wf = F_HA;
                if (s.cnt < HA_LEN - 10'h001) begin
                  n.wd = s.bufm[s.cnt[8:0]];
                end else if (s.cnt == HA_LEN - 10'h001) begin
                  n.wd = HA_END_BYTE;
                end else begin
                  n.wd = 8'h00;
                  n.wf = F_GAP;
                end
              end
              FK_FMT: begin
                if (s.cnt < ID_LEN) begin
                  n.wf = F_ID;
                  n.wd = s.bufm[s.cnt[8:0]];
                  n.winv = (s.op == OP_DFMT) || s.bufm[0][7];
                end else begin
                  n.wf = F_DATA;
                  n.wd = (s.op == OP_DFMT) ? s.cfg_c[7:0] ^ s.cnt[7:0]
                                           : s.cfg_c[7:0];
                end
              end
              default: begin
                if (s.cnt < 10'(PHASE_LOCK)) begin
                  n.wd = 8'h00;
                  n.wf = F_PLO;
                end else if (s.cnt == 10'(PHASE_LOCK)) begin
                  n.wd = SYNC_BYTE;
                  n.wf = F_SYNC;
                end else begin
                  i = s.cnt - 10'(PHASE_LOCK) - 10'h001;
                  n.wf = F_DATA;
                  n.wd = (i < s.blen) ? s.bufm[i[8:0]] : 8'h00;
                end
              end
            endcase
          end
        end
      end
      default: ;
    endcase

    if (fin) begin
      n.st = S_IDLE;
      n.eop = 1'b1;
    end
  end

  // The whole state is one register; the filler resets to its preset.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= S_IDLE;
      s.cfg_c <= CFG_C_RST;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign mem_req = s.mreq;
  assign mem_we = s.mwe;
  assign mem_addr = s.maddr;
  assign mem_wdata = s.mwd;
  assign med_wr_valid = s.wv;
  assign med_wr_data = s.wd;
  assign med_wr_field = s.wf;
  assign med_wr_crc_inv = s.winv;
  assign med_search = (s.st == S_SRCH);
  assign med_read = (s.st == S_RDAT);
  assign med_raw_ecc = (s.op == OP_DRD) || (s.op == OP_DWR);
  assign med_cyl = s.cfg_a[9:0];
  assign med_track = s.cfg_b[15:8];
  assign med_lower = s.cfg_b[8];
  assign busy = (s.st != S_IDLE);
  assign eop = s.eop;

  // Checks on the sequencer.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_start;
    s.st == S_IDLE && reg_we && reg_addr == RA_TASK;
  endsequence
  sequence s_fail_end;
    s.st == S_RDAT && med_rd_end && med_rd_err && s.op == OP_RD;
  endsequence

  property p_zero_range;
    s_start and (s.range == 16'h0000) |=> eop && !busy;
  endproperty
  a_zero_range: assert property (p_zero_range)
    else $error("zero range did not end task");
  property p_fmt_range;
    s_start and (s.range != 16'h0000) and (s.range != FMT_RANGE)
      and is_fmt(op_of(reg_wdata, s.dir)) and !reg_wdata[TW_HA]
      |=> s.prog && eop ##1 !busy;
  endproperty
  a_fmt_range: assert property (p_fmt_range)
    else $error("bad format range not flagged");
  property p_range_dec;
    mem_ack && (s.st == S_DRAIN || s.st == S_FILL) && s.mreq
      |=> s.range == $past(s.range) - 16'h0001;
  endproperty
  a_range_dec: assert property (p_range_dec)
    else $error("range not decremented per byte");
  property p_not_found;
    s.st == S_SRCH && med_index && s.idx == 2'h1 && !med_id_valid
      |=> s.nf && eop && !busy;
  endproperty
  a_not_found: assert property (p_not_found)
    else $error("search failure not posted");
  property p_no_retry;
    s_fail_end and s.task_w[TW_NO_RETRY]
      |=> s.rderr && !busy && s.cfg_b == $past(s.cfg_b);
  endproperty
  a_no_retry: assert property (p_no_retry)
    else $error("data error did not stop task");
  property p_retry;
    s_fail_end and !s.task_w[TW_NO_RETRY] and s.retry == 4'h0
      |=> s.st == S_SRCH && s.retry == 4'h1;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry not taken");
  property p_sect_inc;
    s.st == S_RDAT && med_rd_end && !med_rd_err && s.op == OP_RD
      |=> s.cfg_b[7:0] == $past(s.cfg_b[7:0]) + 8'h01 ##1 s.st == S_DRAIN;
  endproperty
  a_sect_inc: assert property (p_sect_inc)
    else $error("sector number not advanced");
  property p_id_err;
    s.st == S_RDID && med_id_valid && med_id_err && !s.task_w[TW_CRC_IGN]
      && s.range > 16'h0004
      |=> s.range == $past(s.range) - 16'h0004 && s.rderr && !busy;
  endproperty
  a_id_err: assert property (p_id_err)
    else $error("ID error range handling wrong");
  property p_filler;
    med_wr_valid && s.fk == FK_FMT && s.wf == F_DATA && s.op == OP_FMTW
      |-> med_wr_data == s.cfg_c[7:0];
  endproperty
  a_filler: assert property (p_filler)
    else $error("format data not filler");
  property p_diag_crc;
    med_wr_valid && s.wf == F_ID && s.op == OP_DFMT |-> med_wr_crc_inv;
  endproperty
  a_diag_crc: assert property (p_diag_crc)
    else $error("diagnostic ID CRC not inverted");
endmodule

// ---- verification/dkc_far_model.sv ----
`timescale 1ns/1ps
// Main memory and one disk surface, as the sequencer sees them.
module dkc_far_model (
  input wire logic ref_clk, // Clock.
  input wire logic slow, // Answer slowly.
  input wire logic hit, // Target ID passes the head.
  input wire logic rd_err, // Data fields read back bad.
  input wire logic [31:0] want_id, // Target ID image.
  input wire logic mem_req, // Byte request.
  input wire logic mem_we, // Request writes memory.
  input wire logic [23:0] mem_addr, // Byte address.
  input wire logic [7:0] mem_wdata, // Byte to store.
  output logic [7:0] mem_rdata, // Fetched byte.
  output logic mem_ack, // Request done.
  output logic med_index, // Index pulse.
  output logic med_id_valid, // ID read pulse.
  output logic [31:0] med_id, // ID contents.
  output logic med_rd_valid, // Data byte strobe.
  output logic [7:0] med_rd_data, // Data byte.
  output logic med_rd_end, // Field end.
  output logic med_rd_err, // Field bad.
  output logic med_wr_ready, // Media takes the byte.
  input wire logic med_wr_valid, // Byte offered.
  input wire logic [7:0] med_wr_data, // Byte offered.
  input wire dkc_pkg::dkc_field_type med_wr_field, // Byte kind.
  input wire logic med_wr_crc_inv, // Complement this CRC.
  input wire logic med_search, // Looking for an ID.
  input wire logic med_read // Read a field.
);
  import dkc_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] wbuf [0:599];
  dkc_field_type wfld [0:599];
  logic winv [0:599];
  int wcnt, n_ack, n_read, rev, i, n;
  initial begin
    for (i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'ha5;
    {mem_ack, med_index, med_id_valid, med_rd_valid} = 4'h0;
    {med_rd_end, med_rd_err, med_wr_ready} = 3'h1;
    mem_rdata = 8'h00;
    med_id = 32'h0;
    med_rd_data = 8'h00;
    {wcnt, n_ack, n_read, rev} = 0;
  end
  // One byte at a time; the data line flips between answers so stale data never
  // passes for a fresh byte.
  always @(posedge ref_clk) begin
    if (mem_req && !mem_ack) begin
      if (slow) repeat (2) @(posedge ref_clk);
      mem_ack <= 1'b1;
      n_ack <= n_ack + 1;
      if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
  // The disk spins freely: index every 80 cycles, four IDs per turn.
  // Only the first ID after index can match, so a miss spans whole turns.
  always @(posedge ref_clk) begin
    rev <= (rev == 79) ? 0 : rev + 1;
    med_index <= (rev == 79);
    med_id_valid <= (rev % 16 == 15) && (rev != 79);
    med_id <= (hit && rev == 15) ? want_id : want_id ^ 32'(rev + 1);
    med_wr_ready <= slow ? ~med_wr_ready : 1'b1;
    if (med_wr_valid && med_wr_ready) begin
      wbuf[wcnt] <= med_wr_data;
      wfld[wcnt] <= med_wr_field;
      winv[wcnt] <= med_wr_crc_inv;
      wcnt <= wcnt + 1;
    end
  end
  // A field comes off the head when asked for; a fault rides on its end.
  always @(posedge ref_clk) begin
    if (med_read) begin
      n_read <= n_read + 1;
      n = dut_raw() ? 263 : 256;
      for (int k = 0; k < n; k++) begin
        med_rd_valid <= 1'b1;
        med_rd_data <= k[7:0] ^ 8'h5a;
        med_rd_end <= (k == n - 1);
        med_rd_err <= rd_err && (k == n - 1);
        @(posedge ref_clk);
      end
      {med_rd_valid, med_rd_end, med_rd_err} <= 3'h0;
      med_rd_data <= ~med_rd_data;
      while (med_read) @(posedge ref_clk);
    end
  end
  function automatic logic dut_raw();
    return 1'b0;
  endfunction
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
// Drives the sequencer through its register port against the far model.
module tb_top;
  import dkc_pkg::*;
  logic ref_clk, nrst, reg_we, reg_re, mem_req, mem_we, mem_ack, med_index;
  logic med_id_valid, med_id_err, med_rd_valid, med_rd_end, med_rd_err;
  logic med_wr_valid, med_wr_crc_inv, med_wr_ready, med_search, med_read;
  logic med_raw_ecc, med_lower, busy, eop, slow, hit, rd_err;
  logic [2:0] reg_addr, fns [3];
  logic [15:0] reg_wdata, reg_rdata, rv, td;
  logic [MADDR_W-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, med_rd_data, med_wr_data, med_track;
  logic [31:0] med_id, want_id;
  logic [9:0] med_cyl;
  dkc_field_type med_wr_field;
  int n_errors, check_count, cyc;
  dkc_seq #(.SECTORS(2)) dut (.*);
  dkc_far_model far (.*);
  always #50 ref_clk = ~ref_clk;
  task automatic check(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so take them there.
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic run(input logic [15:0] ctl, adr, rng, tw);
    wr(RA_CTRL, ctl);
    wr(RA_ADDR_LO, adr);
    wr(RA_RANGE, rng);
    {far.wcnt, far.n_ack, far.n_read} = 0;
    wr(RA_TASK, tw);
    for (cyc = 0; cyc < 20000 && eop !== 1'b1; cyc++) begin
      @(posedge ref_clk);
      #1;
    end
    check("eop", eop, 1);
  endtask
  task automatic final_report;
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A hang is cut short well past the longest expected sequence.
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end
  initial begin
    {ref_clk, nrst, reg_we, reg_re, med_id_err, slow, rd_err} = 7'h0;
    {reg_addr, reg_wdata, n_errors, check_count} = 0;
    hit = 1'b1;
    want_id = 32'h01230504;
    td = {5'b10000, FN_DATA, 8'h00};
    fns = '{FN_FMT, FN_DDATA, FN_DDATA};
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    rd(RA_CFG_C); check("filler", rv, 16'h006d);
    wr(RA_CFG_A, 16'h0123);
    wr(RA_CFG_B, 16'h0504);
    check("track", {med_track, med_lower}, {8'h05, 1'b1});
    run(16'h0000, 16'h0010, 16'h0000, td);
    check("zero_end", cyc, 0);
    check("zero_mem", far.n_ack, 0);
    // Slow memory and media while writing a short sector.
    slow = 1'b1;
    run(16'h0000, 16'h0010, 16'h0010, td);
    slow = 1'b0;
    rd(RA_RANGE); check("w_range", rv, 0);
    check("w_fetch", far.n_ack, 16);
    check("w_addr", mem_addr, 24'h000020);
    check("w_len", far.wcnt, 269);
    check("w_plo", {far.wfld[11], far.wbuf[11]}, {F_PLO, 8'h00});
    check("w_sync", {far.wfld[12], far.wbuf[12]}, {F_SYNC, SYNC_BYTE});
    check("w_data", far.wbuf[28], 8'h1f ^ 8'ha5);
    check("w_pad", far.wbuf[29], 0);
    wr(RA_CFG_B, 16'h0504);
    run(16'h0001, 16'h0040, 16'h0008, td);
    check("r_first", far.mem[8'h40], 8'h5a);
    check("r_last", far.mem[8'h47], 8'h5d);
    check("r_over", far.mem[8'h48], 8'h48 ^ 8'ha5);
    rd(RA_CFG_B); check("r_sector", rv, 16'h0505);
    // A bad data field, first with retries off, then with them on.
    rd_err = 1'b1;
    want_id = 32'h01230505;
    run(16'h0001, 16'h0040, 16'h0008, td | 16'h0002);
    check("e_reads", far.n_read, 1);
    rd(RA_STAT); check("e_flag", rv[11], 1);
    rd(RA_CFG_B); check("e_sector", rv, 16'h0505);
    rd(RA_RANGE); check("e_range", rv, 8);
    run(16'h0001, 16'h0040, 16'h0008, td);
    check("e_retry", far.n_read > 1, 1);
    {rd_err, hit} = 2'h0;
    med_id_err <= 1'b1;
    run(16'h0001, 16'h0040, 16'h0008, td | 16'h0002);
    rd(RA_STAT); check("n_flag", rv[8], 1);
    check("n_err", rv[11], 1);
    // Format read ID: the first ID comes back bad and stops the task.
    run(16'h0001, 16'h0080, 16'h0008, {5'b10000, FN_FMT, 8'h00});
    rd(RA_RANGE); check("i_range", rv, 4);
    rd(RA_STAT); check("i_err", rv[11], 1);
    for (int j = 0; j < 3; j++) begin
      run(16'(j / 2), 16'h0000, 16'h0005, {5'b10000, fns[j], 8'h00});
      rd(RA_STAT); check("prog_err", rv[10], 1);
    end
    // Two-sector format, plain then diagnostic; sector 0 is marked bad.
    far.mem[8'h80] = 8'hc1;
    for (int j = 0; j < 2; j++) begin
      run(16'h0, 16'h0080, 16'h0008, {5'b10000, j ? FN_DFMT : FN_FMT, 8'h00});
      check("f_len", far.wcnt, 520);
      check("f_id", far.wbuf[260], 8'h84 ^ 8'ha5);
      check("f_fill", far.wbuf[265], j ? 8'h68 : 8'h6d);
      check("f_inv", {far.winv[0], far.winv[260]}, {1'b1, j[0]});
    end
    final_report();
  end
endmodule
